/* File: logic/overlay_pkg.sv */
// Function
// - Frame sync, line sync or both from the connector align graphics timing.
// - Lock control bit 7 enables frame-sync lock, bit 6 line-sync lock, independently.
// - With the strap set, all three external controls held low passes connector video through whole frame, except in mode 11.
// - Mode 01 replaces each pixel sampled with external select low.
// - Mode 11 drives select low on colour-key hits and substitutes connector pixel.
// - Windowed keying applies only inside the programmed horizontal and vertical window.
// - Mode 10 raises window key hit inside window on key match and substitutes.
// - Select and colour-key overlay need the connector strap, not lock, before substitution.
// - Control bit 5 enables DAC switching; bits 4-2 give connector colour format.
package overlay_pkg;
   // Register indices on the graphics controller data port.
   localparam logic [7:0] IDX_OVL_CTRL = 8'h40;
   localparam logic [7:0] IDX_KEY_LO = 8'h41;
   localparam logic [7:0] IDX_KEY_HI = 8'h42;
   localparam logic [7:0] IDX_MASK_LO = 8'h43;
   localparam logic [7:0] IDX_MASK_HI = 8'h44;
   localparam logic [7:0] IDX_WIN_H_BEGIN = 8'h45;
   localparam logic [7:0] IDX_WIN_H_FINISH = 8'h46;
   localparam logic [7:0] IDX_WIN_H_ALIGN = 8'h47;
   localparam logic [7:0] IDX_WIN_V_BEGIN = 8'h48;
   localparam logic [7:0] IDX_WIN_V_FINISH = 8'h49;
   localparam logic [7:0] IDX_WIN_V_HIGH = 8'h4a;
   localparam logic [7:0] IDX_LOCK_CTRL = 8'h4b;
   localparam logic [7:0] REG8_RESET = 8'h00;
   localparam logic [15:0] REG16_RESET = 16'h0000;
   // Field positions.
   localparam int LOCK_FRAME_BIT = 7;
   localparam int LOCK_LINE_BIT = 6;
   localparam int DAC_SWITCH_BIT = 5;
   localparam int DAC_FMT_HI = 4;
   localparam int DAC_FMT_LO = 2;
   localparam int MODE_HI = 1;
   localparam int MODE_LO = 0;
   // Overlay modes held in control bits 1:0.
   localparam logic [1:0] MODE_OFF = 2'h0;
   localparam logic [1:0] MODE_EXT_SELECT = 2'h1;
   localparam logic [1:0] MODE_WIN_KEY = 2'h2;
   localparam logic [1:0] MODE_FULL_KEY = 2'h3;
   // Raster geometry of the graphics timing.
   localparam logic [9:0] H_TOTAL = 10'h0320;
   localparam logic [9:0] V_TOTAL = 10'h020d;
   localparam logic [9:0] POS_ZERO = 10'h000;
   localparam logic [9:0] POS_ONE = 10'h001;

   // One sample of the feature connector, carried across the clock boundary as a unit.
   typedef struct packed {
      logic [15:0] pixel;
      logic select_n;
      logic sync_disable_n;
      logic clock_disable_n;
      logic frame_sync;
      logic line_sync;
   } ext_sample_t;
   localparam ext_sample_t EXT_IDLE = '{pixel: 16'h0000, select_n: 1'b1,
      sync_disable_n: 1'b1, clock_disable_n: 1'b1, frame_sync: 1'b0, line_sync: 1'b0};
endpackage : overlay_pkg

/* File: logic/video_overlay_genlock.sv */
`timescale 1ns/1ps
module video_overlay_genlock (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_link_clk,
   input wire logic [7:0] i_reg_index,
   input wire logic [7:0] i_reg_wdata,
   input wire logic i_reg_wr,
   output logic [7:0] o_reg_rdata,
   input wire logic i_feature_port_strap,
   input wire logic [15:0] i_gfx_pixel,
   input wire logic [15:0] i_ext_pixel,
   input wire logic i_ext_pixel_select_n,
   output logic o_ext_pixel_select_n,
   output logic o_ext_pixel_select_n_oe,
   input wire logic i_ext_sync_disable_n,
   input wire logic i_ext_clock_disable_n,
   input wire logic i_ext_frame_sync,
   input wire logic i_ext_line_sync,
   output logic [15:0] o_pixel,
   output logic o_pixel_from_ext,
   output logic o_window_key_hit,
   output logic o_dac_switch,
   output logic [2:0] o_dac_format,
   output logic [9:0] o_hpos,
   output logic [9:0] o_vpos,
   output logic o_genlock_locked,
   output logic o_feature_enabled
);

   // Link domain: pin samples, held word and handshake request.
   overlay_pkg::ext_sample_t pin_s1_r;
   overlay_pkg::ext_sample_t pin_s2_r;
   overlay_pkg::ext_sample_t hold_r;
   logic req_r;
   logic ack_s1_r;
   logic ack_s2_r;
   // Main domain.
   logic req_s1_r;
   logic req_s2_r;
   logic req_s3_r;
   logic ack_r;
   overlay_pkg::ext_sample_t ext_r;
   logic frame_prev_r;
   logic line_prev_r;
   logic strap_s1_r;
   logic strap_s2_r;
   logic strap_taken_r;
   logic feature_en_r;
   logic [7:0] ovl_ctrl_r;
   logic [15:0] key_r;
   logic [15:0] mask_r;
   logic [7:0] win_h_begin_r;
   logic [7:0] win_h_finish_r;
   logic [7:0] win_h_align_r;
   logic [7:0] win_v_begin_r;
   logic [7:0] win_v_finish_r;
   logic [7:0] win_v_high_r;
   logic [7:0] lock_ctrl_r;
   logic [9:0] h_cnt_r;
   logic [9:0] v_cnt_r;
   logic locked_r;

   // Connector pins are double-registered on the link clock before anything reads them.
   always_ff @(posedge i_link_clk or posedge i_rst) begin
      if (i_rst) begin
         pin_s1_r <= overlay_pkg::EXT_IDLE;
         pin_s2_r <= overlay_pkg::EXT_IDLE;
      end else begin
         pin_s1_r <= '{pixel: i_ext_pixel, select_n: i_ext_pixel_select_n,
            sync_disable_n: i_ext_sync_disable_n, clock_disable_n: i_ext_clock_disable_n,
            frame_sync: i_ext_frame_sync, line_sync: i_ext_line_sync};
         pin_s2_r <= pin_s1_r;
      end
   end

   // Acknowledge toggle returns from the main domain through two flip-flops.
   always_ff @(posedge i_link_clk or posedge i_rst) begin
      if (i_rst) begin
         ack_s1_r <= 1'b0;
         ack_s2_r <= 1'b0;
      end else begin
         ack_s1_r <= ack_r;
         ack_s2_r <= ack_s1_r;
      end
   end

   // The held word only changes when the previous one was taken, so the main side never
   // sees it mid-change. Samples between handshakes are dropped; syncs last many pixels.
   always_ff @(posedge i_link_clk or posedge i_rst) begin
      if (i_rst) begin
         hold_r <= overlay_pkg::EXT_IDLE;
         req_r <= 1'b0;
      end else if (req_r == ack_s2_r) begin
         hold_r <= pin_s2_r;
         req_r <= ~req_r;
      end
   end

   // Request toggle synchroniser; only the second and third stages feed the edge test.
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         req_s1_r <= 1'b0;
         req_s2_r <= 1'b0;
         req_s3_r <= 1'b0;
      end else begin
         req_s1_r <= req_r;
         req_s2_r <= req_s1_r;
         req_s3_r <= req_s2_r;
      end
   end

   // Take the held word on each new request and answer with the acknowledge toggle.
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         ext_r <= overlay_pkg::EXT_IDLE;
         ack_r <= 1'b0;
      end else if (req_s2_r != req_s3_r) begin
         ext_r <= hold_r;
         ack_r <= req_s2_r;
      end
   end

   // The strap synchroniser keeps sampling under reset, so it already holds the strapped
   // level when reset lets go; a reset synchroniser would always hand over zero.
   always_ff @(posedge i_clk) begin
      strap_s1_r <= i_feature_port_strap;
      strap_s2_r <= strap_s1_r;
   end

   // The strap is caught once after reset release, never under the asynchronous reset.
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         strap_taken_r <= 1'b0;
         feature_en_r <= 1'b0;
      end else begin
         strap_taken_r <= 1'b1;
         if (!strap_taken_r) begin
            feature_en_r <= strap_s2_r;
         end
      end
   end

   // Register writes through the index and data port.
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         ovl_ctrl_r <= overlay_pkg::REG8_RESET;
         key_r <= overlay_pkg::REG16_RESET;
         mask_r <= overlay_pkg::REG16_RESET;
         win_h_begin_r <= overlay_pkg::REG8_RESET;
         win_h_finish_r <= overlay_pkg::REG8_RESET;
         win_h_align_r <= overlay_pkg::REG8_RESET;
         win_v_begin_r <= overlay_pkg::REG8_RESET;
         win_v_finish_r <= overlay_pkg::REG8_RESET;
         win_v_high_r <= overlay_pkg::REG8_RESET;
         lock_ctrl_r <= overlay_pkg::REG8_RESET;
      end else if (i_reg_wr) begin
         case (i_reg_index)
            overlay_pkg::IDX_OVL_CTRL: ovl_ctrl_r <= i_reg_wdata;
            overlay_pkg::IDX_KEY_LO: key_r[7:0] <= i_reg_wdata;
            overlay_pkg::IDX_KEY_HI: key_r[15:8] <= i_reg_wdata;
            overlay_pkg::IDX_MASK_LO: mask_r[7:0] <= i_reg_wdata;
            overlay_pkg::IDX_MASK_HI: mask_r[15:8] <= i_reg_wdata;
            overlay_pkg::IDX_WIN_H_BEGIN: win_h_begin_r <= i_reg_wdata;
            overlay_pkg::IDX_WIN_H_FINISH: win_h_finish_r <= i_reg_wdata;
            overlay_pkg::IDX_WIN_H_ALIGN: win_h_align_r <= i_reg_wdata;
            overlay_pkg::IDX_WIN_V_BEGIN: win_v_begin_r <= i_reg_wdata;
            overlay_pkg::IDX_WIN_V_FINISH: win_v_finish_r <= i_reg_wdata;
            overlay_pkg::IDX_WIN_V_HIGH: win_v_high_r <= i_reg_wdata;
            overlay_pkg::IDX_LOCK_CTRL: lock_ctrl_r <= i_reg_wdata;
            default: ;
         endcase
      end
   end

   // Read data follows the index one cycle later; unknown indices read zero.
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_reg_rdata <= overlay_pkg::REG8_RESET;
      end else begin
         case (i_reg_index)
            overlay_pkg::IDX_OVL_CTRL: o_reg_rdata <= ovl_ctrl_r;
            overlay_pkg::IDX_KEY_LO: o_reg_rdata <= key_r[7:0];
            overlay_pkg::IDX_KEY_HI: o_reg_rdata <= key_r[15:8];
            overlay_pkg::IDX_MASK_LO: o_reg_rdata <= mask_r[7:0];
            overlay_pkg::IDX_MASK_HI: o_reg_rdata <= mask_r[15:8];
            overlay_pkg::IDX_WIN_H_BEGIN: o_reg_rdata <= win_h_begin_r;
            overlay_pkg::IDX_WIN_H_FINISH: o_reg_rdata <= win_h_finish_r;
            overlay_pkg::IDX_WIN_H_ALIGN: o_reg_rdata <= win_h_align_r;
            overlay_pkg::IDX_WIN_V_BEGIN: o_reg_rdata <= win_v_begin_r;
            overlay_pkg::IDX_WIN_V_FINISH: o_reg_rdata <= win_v_finish_r;
            overlay_pkg::IDX_WIN_V_HIGH: o_reg_rdata <= win_v_high_r;
            overlay_pkg::IDX_LOCK_CTRL: o_reg_rdata <= lock_ctrl_r;
            default: o_reg_rdata <= overlay_pkg::REG8_RESET;
         endcase
      end
   end

   // Rising edges of the incoming syncs, qualified by their lock enables.
   logic frame_edge;
   logic line_edge;
   logic lock_frame_en;
   logic lock_line_en;
   assign lock_frame_en = lock_ctrl_r[overlay_pkg::LOCK_FRAME_BIT];
   assign lock_line_en = lock_ctrl_r[overlay_pkg::LOCK_LINE_BIT];
   assign frame_edge = feature_en_r & lock_frame_en & ext_r.frame_sync & ~frame_prev_r;
   assign line_edge = feature_en_r & lock_line_en & ext_r.line_sync & ~line_prev_r;

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         frame_prev_r <= 1'b0;
         line_prev_r <= 1'b0;
      end else begin
         frame_prev_r <= ext_r.frame_sync;
         line_prev_r <= ext_r.line_sync;
      end
   end

   // Raster counters; a frame sync restarts the frame, a line sync restarts the line.
   // Frame sync wins when both arrive together, since it also implies a new line.
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         h_cnt_r <= overlay_pkg::POS_ZERO;
         v_cnt_r <= overlay_pkg::POS_ZERO;
      end else if (frame_edge) begin
         h_cnt_r <= overlay_pkg::POS_ZERO;
         v_cnt_r <= overlay_pkg::POS_ZERO;
      end else if (line_edge || h_cnt_r == overlay_pkg::H_TOTAL - overlay_pkg::POS_ONE) begin
         h_cnt_r <= overlay_pkg::POS_ZERO;
         if (v_cnt_r == overlay_pkg::V_TOTAL - overlay_pkg::POS_ONE) begin
            v_cnt_r <= overlay_pkg::POS_ZERO;
         end else begin
            v_cnt_r <= v_cnt_r + overlay_pkg::POS_ONE;
         end
      end else begin
         h_cnt_r <= h_cnt_r + overlay_pkg::POS_ONE;
      end
   end

   // Lock is reported once an enabled sync has aligned the raster; dropping both
   // enables clears it. Substitution itself is not held back by it.
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         locked_r <= 1'b0;
      end else if (frame_edge || line_edge) begin
         locked_r <= 1'b1;
      end else if (!lock_frame_en && !lock_line_en) begin
         locked_r <= 1'b0;
      end
   end

   // Window bounds: horizontal low bits come from the alignment register, vertical
   // high bits from the overflow register.
   logic [9:0] win_h_lo;
   logic [9:0] win_h_hi;
   logic [9:0] win_v_lo;
   logic [9:0] win_v_hi;
   assign win_h_lo = {win_h_begin_r[6:0], win_h_align_r[2:0]};
   assign win_h_hi = {win_h_finish_r[6:0], win_h_align_r[6:4]};
   assign win_v_lo = {win_v_high_r[1:0], win_v_begin_r};
   assign win_v_hi = {win_v_high_r[3:2], win_v_finish_r};

   // Per-pixel decisions.
   logic [1:0] mode;
   logic key_match;
   logic in_window;
   logic pass_through;
   logic substitute;
   logic drive_select;
   logic win_hit;
   assign mode = ovl_ctrl_r[overlay_pkg::MODE_HI:overlay_pkg::MODE_LO];
   assign key_match = ((i_gfx_pixel ^ key_r) & mask_r) == 16'h0000;
   assign in_window = (h_cnt_r >= win_h_lo) && (h_cnt_r <= win_h_hi)
      && (v_cnt_r >= win_v_lo) && (v_cnt_r <= win_v_hi);
   assign drive_select = feature_en_r && (mode == overlay_pkg::MODE_FULL_KEY);
   assign win_hit = feature_en_r && (mode == overlay_pkg::MODE_WIN_KEY)
      && in_window && key_match;
   // Pass-through needs all three controls low, and is off while the select is driven.
   assign pass_through = feature_en_r && !drive_select && !ext_r.select_n
      && !ext_r.sync_disable_n && !ext_r.clock_disable_n;

   always_comb begin
      case (mode)
         overlay_pkg::MODE_OFF: substitute = 1'b0;
         overlay_pkg::MODE_EXT_SELECT: substitute = feature_en_r && !ext_r.select_n;
         overlay_pkg::MODE_WIN_KEY: substitute = win_hit;
         overlay_pkg::MODE_FULL_KEY: substitute = drive_select && key_match;
         default: substitute = 1'b0;
      endcase
   end

   // Pixel, select pin and key-hit outputs, all registered together so they align.
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_pixel <= overlay_pkg::REG16_RESET;
         o_pixel_from_ext <= 1'b0;
         o_ext_pixel_select_n <= 1'b1;
         o_ext_pixel_select_n_oe <= 1'b0;
         o_window_key_hit <= 1'b0;
      end else begin
         o_pixel <= (pass_through || substitute) ? ext_r.pixel : i_gfx_pixel;
         o_pixel_from_ext <= pass_through || substitute;
         o_ext_pixel_select_n <= ~(drive_select && key_match);
         o_ext_pixel_select_n_oe <= drive_select;
         o_window_key_hit <= win_hit;
      end
   end
   // DAC switching marks overlay pixels with the connector colour format.
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_dac_switch <= 1'b0;
         o_dac_format <= 3'h0;
      end else begin
         o_dac_switch <= ovl_ctrl_r[overlay_pkg::DAC_SWITCH_BIT]
            && (pass_through || substitute);
         o_dac_format <= ovl_ctrl_r[overlay_pkg::DAC_FMT_HI:overlay_pkg::DAC_FMT_LO];
      end
   end

   // Status and raster position outputs.
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_hpos <= overlay_pkg::POS_ZERO;
         o_vpos <= overlay_pkg::POS_ZERO;
         o_genlock_locked <= 1'b0;
         o_feature_enabled <= 1'b0;
      end else begin
         o_hpos <= h_cnt_r;
         o_vpos <= v_cnt_r;
         o_genlock_locked <= locked_r;
         o_feature_enabled <= feature_en_r;
      end
   end

endmodule : video_overlay_genlock

/* File: sim/ext_video_source.sv */
`timescale 1ns/1ps
module ext_video_source #(
   parameter logic [15:0] PIX = 16'ha5c3
) (
   input wire logic i_link_clk,
   input wire logic i_rst,
   input wire logic i_pass,
   input wire logic i_sel_n,
   input wire logic i_frame,
   input wire logic i_line,
   output overlay_pkg::ext_sample_t o_smp
);
   // The stream never pauses, so the device always has a fresh word.
   always_ff @(posedge i_link_clk or posedge i_rst) begin
      if (i_rst) begin
         o_smp <= overlay_pkg::EXT_IDLE;
      end else begin
         o_smp.pixel <= PIX;
         o_smp.select_n <= i_pass ? 1'b0 : i_sel_n;
         o_smp.sync_disable_n <= !i_pass;
         o_smp.clock_disable_n <= !i_pass;
         o_smp.frame_sync <= i_frame;
         o_smp.line_sync <= i_line;
      end
   end
endmodule : ext_video_source

/* File: sim/overlay_monitor.sv */
`timescale 1ns/1ps
module overlay_monitor (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [7:0] i_reg_index,
   input wire logic [7:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic [7:0] o_reg_rdata,
   input wire logic [15:0] i_gfx_pixel,
   input wire logic [15:0] o_pixel,
   input wire logic o_pixel_from_ext,
   input wire logic o_window_key_hit,
   input wire logic o_ext_pixel_select_n,
   input wire logic o_ext_pixel_select_n_oe,
   input wire logic o_dac_switch,
   input wire logic [9:0] o_hpos,
   input wire logic [9:0] o_vpos,
   input wire logic o_genlock_locked,
   input wire logic o_feature_enabled
);
   logic [7:0] sh_r [8'h40:8'h4b];
   logic key_ok;
   logic [1:0] mode;
   // Shadow copy of the registers, so checks need not reach into the design.
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         sh_r <= '{default: 8'h00};
      end else if (i_reg_wr && i_reg_index >= 8'h40 && i_reg_index <= 8'h4b) begin
         sh_r[i_reg_index] <= i_reg_wdata;
      end
   end
   // Key match on the pixel entering this cycle.
   assign key_ok = ((i_gfx_pixel ^ {sh_r[8'h42], sh_r[8'h41]})
      & {sh_r[8'h44], sh_r[8'h43]}) == 16'h0000;
   assign mode = sh_r[8'h40][1:0];
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   sequence s_wr_ctl;
      i_reg_wr && i_reg_index == overlay_pkg::IDX_OVL_CTRL;
   endsequence
   sequence s_hold_ctl;
      !i_reg_wr && i_reg_index == overlay_pkg::IDX_OVL_CTRL;
   endsequence
   chk_ctl_readback: assert property (s_wr_ctl ##1 s_hold_ctl
      |=> o_reg_rdata == $past(i_reg_wdata, 2)) else $error("control readback wrong");
   chk_gfx_passes: assert property (!o_pixel_from_ext
      |-> o_pixel == $past(i_gfx_pixel)) else $error("graphics pixel altered");
   chk_dac_gate: assert property (o_dac_switch
      |-> o_pixel_from_ext && $past(sh_r[8'h40][5])) else $error("dac switch wrong");
   chk_win_hit: assert property (o_window_key_hit |-> o_pixel_from_ext
      && $past(key_ok) && $past(mode) == overlay_pkg::MODE_WIN_KEY) else $error("hit wrong");
   chk_select_drive: assert property (o_ext_pixel_select_n_oe
      |-> $past(mode) == overlay_pkg::MODE_FULL_KEY && o_feature_enabled)
      else $error("select driven wrongly");
   chk_select_low: assert property (o_ext_pixel_select_n_oe && !o_ext_pixel_select_n
      |-> $past(key_ok) && o_pixel_from_ext) else $error("select low without key");
   chk_strap_gate: assert property (o_pixel_from_ext |-> o_feature_enabled)
      else $error("substitution without connector");
   chk_lock_clear: assert property ((sh_r[8'h4b][7:6] == 2'b00) [*3]
      |-> !o_genlock_locked) else $error("lock without enable");
   chk_raster_range: assert property (o_hpos < overlay_pkg::H_TOTAL
      && o_vpos < overlay_pkg::V_TOTAL) else $error("raster out of range");
endmodule : overlay_monitor
bind video_overlay_genlock overlay_monitor mon_u (.i_clk(i_clk), .i_rst(i_rst),
   .i_reg_index(i_reg_index), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr),
   .o_reg_rdata(o_reg_rdata), .i_gfx_pixel(i_gfx_pixel), .o_pixel(o_pixel),
   .o_pixel_from_ext(o_pixel_from_ext), .o_window_key_hit(o_window_key_hit),
   .o_ext_pixel_select_n(o_ext_pixel_select_n),
   .o_ext_pixel_select_n_oe(o_ext_pixel_select_n_oe), .o_dac_switch(o_dac_switch),
   .o_hpos(o_hpos), .o_vpos(o_vpos), .o_genlock_locked(o_genlock_locked),
   .o_feature_enabled(o_feature_enabled));

/* File: sim/video_overlay_genlock_bench.sv */
`timescale 1ns/1ps
module video_overlay_genlock_bench;
   localparam logic [15:0] PIX = 16'ha5c3;
   localparam logic [7:0] WHB = 8'h02;
   localparam logic [7:0] WHF = 8'h05;
   localparam logic [7:0] WAL = 8'h70;
   localparam logic [7:0] CTL [6] = '{8'h00, 8'h00, 8'h01, 8'h01, 8'h36, 8'h2b};
   localparam logic [5:0] PS = 6'h02;
   localparam logic [5:0] SN = 6'h0b;
   localparam logic [7:0] LK [3] = '{8'h80, 8'h40, 8'h40};
   logic i_clk = 1'b0;
   logic i_link_clk = 1'b0;
   logic i_rst = 1'b1;
   logic strap = 1'b1;
   logic [7:0] idx = 8'h00;
   logic [7:0] wd = 8'h00;
   logic wr = 1'b0;
   logic [15:0] gfx = 16'h0000;
   logic pass = 1'b0;
   logic seln = 1'b1;
   logic frm = 1'b0;
   logic lin = 1'b0;
   logic [15:0] key, mask;
   logic [31:0] seed = 32'h0000_3cd2;
   int num_errors = 0;
   int comparisons = 0;
   overlay_pkg::ext_sample_t smp;
   logic sel_o, sel_oe, sel_w, from_ext, hit, dsw, lkd, fen;
   logic [7:0] rdata;
   logic [15:0] pix;
   logic [2:0] dfmt;
   logic [9:0] hpos, vpos;
   // The select pin is shared; the device wins while its enable is up.
   assign sel_w = sel_oe ? sel_o : smp.select_n;
   video_overlay_genlock dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_link_clk(i_link_clk),
      .i_reg_index(idx), .i_reg_wdata(wd), .i_reg_wr(wr), .o_reg_rdata(rdata),
      .i_feature_port_strap(strap), .i_gfx_pixel(gfx), .i_ext_pixel(smp.pixel),
      .i_ext_pixel_select_n(sel_w), .o_ext_pixel_select_n(sel_o),
      .o_ext_pixel_select_n_oe(sel_oe), .i_ext_sync_disable_n(smp.sync_disable_n),
      .i_ext_clock_disable_n(smp.clock_disable_n), .i_ext_frame_sync(smp.frame_sync),
      .i_ext_line_sync(smp.line_sync), .o_pixel(pix), .o_pixel_from_ext(from_ext),
      .o_window_key_hit(hit), .o_dac_switch(dsw), .o_dac_format(dfmt), .o_hpos(hpos),
      .o_vpos(vpos), .o_genlock_locked(lkd), .o_feature_enabled(fen));
   ext_video_source #(.PIX(PIX)) src_u (.i_link_clk(i_link_clk), .i_rst(i_rst),
      .i_pass(pass), .i_sel_n(seln), .i_frame(frm), .i_line(lin), .o_smp(smp));
   // Two free-running clocks with no phase relation.
   initial forever #5 i_clk = ~i_clk;
   initial begin
      #3.3;
      forever #6 i_link_clk = ~i_link_clk;
   end
   function automatic logic [15:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[15:0];
   endfunction : rnd
   // Expected {from_ext, key_hit, select_oe, select_n} for one pixel.
   function automatic logic [3:0] expect_outs(input logic [1:0] md, input logic ps,
      input logic sn, input logic m, input logic [9:0] h);
      logic w;
      logic k;
      w = h >= {WHB[6:0], WAL[2:0]} && h <= {WHF[6:0], WAL[6:4]};
      k = md == overlay_pkg::MODE_WIN_KEY && m && w;
      return {ps || (md == overlay_pkg::MODE_EXT_SELECT && !sn) || k
         || (md == overlay_pkg::MODE_FULL_KEY && m), k, md == overlay_pkg::MODE_FULL_KEY,
         !(md == overlay_pkg::MODE_FULL_KEY && m)};
   endfunction : expect_outs
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk);
      #1;
      idx = a;
      wd = d;
      wr = 1'b1;
      @(posedge i_clk);
      #1;
      wr = 1'b0;
   endtask : wreg
   task automatic rreg(input logic [7:0] a, output logic [7:0] d);
      @(posedge i_clk);
      #1;
      idx = a;
      repeat (2) @(posedge i_clk);
      #1;
      d = rdata;
   endtask : rreg
   // One overlay mode over a full line; every fourth pixel is forced onto the key.
   task automatic run_mode(input logic [7:0] ctl, input logic ps, input logic sn);
      logic [15:0] prev;
      logic [15:0] r;
      logic [3:0] e;
      logic [3:0] o;
      wreg(overlay_pkg::IDX_OVL_CTRL, ctl);
      pass = ps;
      seln = sn;
      repeat (30) @(posedge i_clk);
      prev = gfx;
      for (int k = 0; k < 820; k++) begin
         @(posedge i_clk);
         #1;
         e = expect_outs(ctl[1:0], ps, sn, ((prev ^ key) & mask) == 16'h0000, hpos);
         o = {from_ext, hit, sel_oe, sel_o | !sel_oe};
         check("outs", {12'h000, e}, {12'h000, o});
         check("pixel", e[3] ? PIX : prev, pix);
         check("dac", {12'h000, ctl[5] && e[3], ctl[4:2]}, {12'h000, dsw, dfmt});
         r = rnd();
         gfx = (k % 4 == 0) ? ((r & ~mask) | (key & mask)) : r;
         prev = gfx;
      end
   endtask : run_mode
   task automatic conclude();
      $display("Checks %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : conclude
   initial begin
      #400000;
      num_errors++;
      conclude();
   end
   initial begin
      logic [7:0] d;
      logic [7:0] r;
      int n;
      repeat (3) @(posedge i_clk);
      #1;
      i_rst = 1'b0;
      repeat (4) @(posedge i_clk);
      // Reset value, then random write and readback; indices outside the map stay zero.
      for (int a = 8'h3f; a <= 8'h4c; a++) begin
         rreg(a[7:0], d);
         check("reset value", 16'h0000, {8'h00, d});
         r = 8'(rnd());
         wreg(a[7:0], r);
         rreg(a[7:0], d);
         if (a < 8'h40 || a > 8'h4b) r = 8'h00;
         check("readback", {8'h00, r}, {8'h00, d});
      end
      key = rnd();
      mask = rnd();
      wreg(overlay_pkg::IDX_KEY_LO, key[7:0]);
      wreg(overlay_pkg::IDX_KEY_HI, key[15:8]);
      wreg(overlay_pkg::IDX_MASK_LO, mask[7:0]);
      wreg(overlay_pkg::IDX_MASK_HI, mask[15:8]);
      wreg(overlay_pkg::IDX_WIN_H_BEGIN, WHB);
      wreg(overlay_pkg::IDX_WIN_H_FINISH, WHF);
      wreg(overlay_pkg::IDX_WIN_H_ALIGN, WAL);
      wreg(overlay_pkg::IDX_WIN_V_BEGIN, 8'h00);
      wreg(overlay_pkg::IDX_WIN_V_FINISH, 8'hff);
      wreg(overlay_pkg::IDX_WIN_V_HIGH, 8'h0c);
      // Frame lock, a frame edge that only line lock is armed for, then line lock.
      for (int c = 0; c < 3; c++) begin
         wreg(overlay_pkg::IDX_LOCK_CTRL, 8'h00);
         repeat (4) @(posedge i_clk);
         check("unlocked", 16'h0000, {15'h0000, lkd});
         wreg(overlay_pkg::IDX_LOCK_CTRL, LK[c]);
         frm = c < 2;
         lin = c == 2;
         n = 0;
         while (lkd !== 1'b1 && n < 60) begin
            @(posedge i_clk);
            #1;
            n++;
         end
         check("locked", {15'h0000, c != 1}, {15'h0000, lkd});
         if (c != 1) check("hpos zeroed", 16'h0001, {15'h0000, hpos < 10'h004});
         if (c == 0) check("vpos zeroed", 16'h0000, {6'h00, vpos});
         frm = 1'b0;
         lin = 1'b0;
         repeat (20) @(posedge i_clk);
      end
      for (int c = 0; c < 6; c++) run_mode(CTL[c], PS[c], SN[c]);
      // A second reset with the strap low must keep pass-through and the mode 11 select drive shut.
      check("feature on", 16'h0001, {15'h0000, fen});
      gfx = 16'h0000;
      strap = 1'b0;
      i_rst = 1'b1;
      repeat (3) @(posedge i_clk);
      #1;
      i_rst = 1'b0;
      wreg(overlay_pkg::IDX_OVL_CTRL, 8'h03);
      pass = 1'b1;
      repeat (40) @(posedge i_clk);
      #1;
      check("feature off", 16'h0000, {13'h0000, fen, from_ext, sel_oe});
      conclude();
   end
endmodule : video_overlay_genlock_bench
